// ### hw/wsc_pkg.sv
// constants, types and decode helpers for the watchdog, sleep and configuration block
package wsc_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_OPTION = 12'h000;
  localparam logic [11:0] ADDR_COMMAND = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CONFIG = 12'h00c;
  // option register layout and reset value
  localparam logic [7:0] OPTION_RESET = 8'h3f;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;
  // command register bits
  localparam int CMD_CLEAR_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  // status register bits
  localparam int ST_SLEEPING_BIT = 0;
  localparam int ST_IN_RESET_BIT = 1;
  localparam int ST_POWERDOWN_BIT = 3;
  localparam int ST_TIMEOUT_BIT = 4;
  // configuration word layout
  localparam int CFG_WIDTH = 12;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_WDT_EN_BIT = 2;
  localparam int CFG_PROT_LSB = 3;
  localparam int CFG_PROT_MSB = 11;
  localparam logic [11:0] CFG_SINGLE_MASK = 12'h00f;
  // timing
  localparam int CLK_KHZ = 100_000;
  localparam int WDT_BASE_MS = 18;
  localparam int WDT_OSC_KHZ = 32;
  localparam int WDT_BASE_TICKS = WDT_BASE_MS * WDT_OSC_KHZ;
  localparam int HOLD_MS = 18;
  localparam int HOLD_CYCLES_NOM = HOLD_MS * CLK_KHZ;
  localparam int WDT_CNT_W = 10;
  localparam int HOLD_CNT_W = 21;
  localparam int PRESC_W = 8;

  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL,
    OSC_STANDARD_CRYSTAL,
    OSC_HIGH_SPEED_CRYSTAL,
    OSC_RESISTOR_CAPACITOR
  } wsc_osc_t;

  typedef enum logic [1:0] {WSC_HOLD, WSC_RUN, WSC_SLEEP} wsc_state_t;

  function automatic wsc_osc_t wsc_osc_decode(input logic [1:0] sel);
    wsc_osc_decode = wsc_osc_t'(sel);
  endfunction : wsc_osc_decode

  function automatic logic wsc_hit(input logic [11:0] addr, input logic [11:0] reg_addr);
    wsc_hit = (addr == reg_addr);
  endfunction : wsc_hit
endpackage : wsc_pkg

// ### hw/wsc_prescaler.sv
// shared 8-bit prescaler, owned by Timer0 or by the watchdog
`timescale 1ns/100ps
module wsc_prescaler
  import wsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic owner_wdt,
  input wire logic [2:0] ratio,
  input wire logic clear,
  // count sources
  input wire logic wdt_base_expire,
  input wire logic timer0_tick,
  // results
  output logic wdt_expire,
  output logic timer0_pulse
);
  logic [PRESC_W-1:0] count;
  logic [PRESC_W:0] next_count;
  logic step;
  logic [PRESC_W-1:0] t0_mask;

  always_comb begin
    step = owner_wdt ? wdt_base_expire : timer0_tick;
    // low ratio+1 bits of the count; all zero once every 2**(ratio+1) steps
    t0_mask = 8'hff >> (3'h7 - ratio);
    next_count = {1'b0, count} + {{PRESC_W{1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (ce) begin
      if (clear) begin
        count <= '0;
      end else if (step) begin
        if (owner_wdt && next_count[ratio]) begin
          count <= '0;
        end else begin
          count <= next_count[PRESC_W-1:0];
        end
      end
    end
  end

  // watchdog sees 2**ratio base periods, 1:1 up to 1:128; Timer0 sees 1:2 up to 1:256
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_expire <= 1'b0;
      timer0_pulse <= 1'b0;
    end else if (ce) begin
      wdt_expire <= !clear && step && owner_wdt && next_count[ratio];
      timer0_pulse <= !clear && step && !owner_wdt
        && ((next_count[PRESC_W-1:0] & t0_mask) == '0);
    end
  end
endmodule : wsc_prescaler

// ### hw/wsc_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module wsc_sync
  import wsc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          // each bit starts at its pin's idle level, so no false event follows reset
          stage1[i] <= RST_VALUE[i];
          sync_out[i] <= RST_VALUE[i];
        end else if (ce) begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule : wsc_sync

// ### hw/wsc_top.sv
// watchdog, sleep control and configuration word decode with an APB register port
`timescale 1ns/100ps
module wsc_top
  import wsc_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYCLES_NOM
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and straps
  input wire logic wdt_osc_pin,
  input wire logic master_clear_n_pin,
  input wire logic [CFG_WIDTH-1:0] config_word,
  input wire logic single_protect_variant,
  // Timer0 side of the shared prescaler
  input wire logic timer0_tick,
  output logic timer0_prescaled,
  // device control
  output logic device_reset,
  output logic osc_driver_en,
  output logic io_hold,
  output logic wdt_enabled,
  output logic [1:0] oscillator_select,
  output logic code_protect_on
);
  wsc_state_t state;
  logic [1:0] pins_sync;
  logic osc_sync;
  logic clear_n_sync;
  logic osc_last;
  logic osc_tick;
  logic [WDT_CNT_W-1:0] wdt_count;
  logic wdt_base_expire;
  logic presc_expire;
  logic wdt_timeout;
  logic [HOLD_CNT_W-1:0] hold_count;
  logic [7:0] option;
  logic owner_wdt;
  logic [2:0] ratio;
  logic [CFG_WIDTH-1:0] cfg;
  logic cfg_taken;
  logic timeout_flag;
  logic powerdown_flag;
  logic access;
  logic setup;
  logic wr_command;
  logic cmd_clear;
  logic cmd_sleep;
  logic wdt_clear;
  logic pin_reset;
  logic [31:0] next_prdata;
  logic next_err;

  // the oscillator pin and master clear come from outside: two flops first
  // master clear starts high, its idle level, so reset release is not seen as a request
  wsc_sync #(.W(2), .RST_VALUE(2'h2)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .async_in({master_clear_n_pin, wdt_osc_pin}),
    .sync_out(pins_sync)
  );

  always_comb begin
    osc_sync = pins_sync[0];
    clear_n_sync = pins_sync[1];
    owner_wdt = option[OPT_ASSIGN_BIT];
    ratio = option[OPT_RATIO_LSB +: 3];
    setup = psel && !penable;
    access = psel && penable && pready;
    wr_command = access && pwrite && wsc_hit(paddr, ADDR_COMMAND);
    cmd_clear = wr_command && pwdata[CMD_CLEAR_BIT] && state == WSC_RUN;
    cmd_sleep = wr_command && pwdata[CMD_SLEEP_BIT] && state == WSC_RUN && !cmd_clear;
    pin_reset = !clear_n_sync && cfg_taken;
    wdt_timeout = wdt_enabled && (owner_wdt ? presc_expire : wdt_base_expire);
  end

  // the watchdog time base is the RC oscillator pin, not clk; clk only samples it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_last <= 1'b0;
      osc_tick <= 1'b0;
    end else if (ce) begin
      osc_last <= osc_sync;
      osc_tick <= osc_sync && !osc_last;
    end
  end

  // clear on instruction, on sleep, on wake and while the reset timer runs
  always_comb begin
    wdt_clear = cmd_clear || cmd_sleep || state == WSC_HOLD;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_count <= '0;
      wdt_base_expire <= 1'b0;
    end else if (ce) begin
      wdt_base_expire <= 1'b0;
      if (wdt_clear || !wdt_enabled) begin
        wdt_count <= '0;
      end else if (osc_tick) begin
        if (wdt_count == WDT_CNT_W'(WDT_BASE_TICKS - 1)) begin
          wdt_count <= '0;
          wdt_base_expire <= 1'b1;
        end else begin
          wdt_count <= wdt_count + WDT_CNT_W'(1);
        end
      end
    end
  end

  // the prescaler is cleared with the watchdog only while it belongs to the watchdog, and for either owner during the reset hold
  wsc_prescaler u_presc (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .owner_wdt(owner_wdt),
    .ratio(ratio),
    .clear((wdt_clear && owner_wdt) || state == WSC_HOLD),
    .wdt_base_expire(wdt_base_expire),
    .timer0_tick(timer0_tick),
    .wdt_expire(presc_expire),
    .timer0_pulse(timer0_prescaled)
  );

  // straps are caught one edge after reset release, never under the reset itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
      cfg_taken <= 1'b0;
    end else if (ce && !cfg_taken) begin
      cfg <= single_protect_variant ? (config_word & CFG_SINGLE_MASK) : config_word;
      cfg_taken <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_enabled <= 1'b0;
      oscillator_select <= 2'b00;
      code_protect_on <= 1'b0;
    end else if (ce) begin
      wdt_enabled <= cfg_taken && cfg[CFG_WDT_EN_BIT];
      oscillator_select <= wsc_osc_decode(cfg[CFG_OSC_LSB +: 2]);
      if (single_protect_variant) begin
        code_protect_on <= cfg_taken && !cfg[CFG_PROT_LSB];
      end else begin
        code_protect_on <= cfg_taken && !(&cfg[CFG_PROT_MSB:CFG_PROT_LSB]);
      end
    end
  end

  // option register, write only from software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      option <= OPTION_RESET;
    end else if (ce) begin
      if (state == WSC_HOLD) begin
        option <= OPTION_RESET;
      end else if (access && pwrite && wsc_hit(paddr, ADDR_OPTION)) begin
        option <= pwdata[7:0];
      end
    end
  end

  // sequencer: reset timer, running, asleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= WSC_HOLD;
      hold_count <= '0;
    end else if (ce) begin
      unique case (state)
        WSC_HOLD: begin
          if (pin_reset || !cfg_taken) begin
            hold_count <= '0;
          end else if (hold_count == HOLD_CNT_W'(HOLD_CYCLES - 1)) begin
            state <= WSC_RUN;
          end else begin
            hold_count <= hold_count + HOLD_CNT_W'(1);
          end
        end
        WSC_RUN: begin
          hold_count <= '0;
          if (pin_reset || wdt_timeout) begin
            state <= WSC_HOLD;
          end else if (cmd_sleep) begin
            state <= WSC_SLEEP;
          end
        end
        WSC_SLEEP: begin
          hold_count <= '0;
          if (pin_reset || wdt_timeout) begin
            state <= WSC_HOLD;
          end
        end
      endcase
    end
  end

  // status flags; a timeout outranks a sleep request arriving in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (ce) begin
      if (state != WSC_HOLD && wdt_timeout) begin
        timeout_flag <= 1'b0;
      end else if (cmd_sleep) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b0;
      end
    end
  end

  // device-facing outputs; the master clear pin is never driven, so the reset stays internal
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_reset <= 1'b1;
      osc_driver_en <= 1'b1;
      io_hold <= 1'b0;
    end else if (ce) begin
      device_reset <= !(state == WSC_RUN && !pin_reset && !wdt_timeout)
        && !(state == WSC_SLEEP && !pin_reset && !wdt_timeout)
        || (state == WSC_HOLD);
      osc_driver_en <= !(cmd_sleep || (state == WSC_SLEEP && !pin_reset && !wdt_timeout));
      io_hold <= cmd_sleep || (state == WSC_SLEEP && !pin_reset && !wdt_timeout);
    end
  end

  // APB read data and error, prepared in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (wsc_hit(paddr, ADDR_STATUS)) begin
      next_prdata[ST_TIMEOUT_BIT] = timeout_flag;
      next_prdata[ST_POWERDOWN_BIT] = powerdown_flag;
      next_prdata[ST_SLEEPING_BIT] = state == WSC_SLEEP;
      next_prdata[ST_IN_RESET_BIT] = state == WSC_HOLD;
    end else if (wsc_hit(paddr, ADDR_CONFIG)) begin
      next_prdata[CFG_WIDTH-1:0] = cfg;
    end else if (!wsc_hit(paddr, ADDR_OPTION) && !wsc_hit(paddr, ADDR_COMMAND)) begin
      next_err = 1'b1;
    end
    if (!pwrite && (wsc_hit(paddr, ADDR_OPTION) || wsc_hit(paddr, ADDR_COMMAND))) begin
      next_prdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && next_err;
      if (setup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule : wsc_top

// ### verification/tb.sv
// self-checking bench for the watchdog, sleep and configuration block
`timescale 1ns/100ps
module tb
  import wsc_pkg::*;
;
  localparam int HOLD = 20;
  logic clk, rst, go, wr, done, err, psel, penable, pwrite, pready, pslverr;
  logic [11:0] addr, paddr, config_word;
  logic [31:0] wdata, rdata, pwdata, prdata;
  logic wdt_osc_pin, master_clear_n_pin, single_protect_variant;
  logic timer0_tick = 1'b0;
  logic timer0_prescaled, device_reset, osc_driver_en, io_hold, wdt_enabled, code_protect_on;
  logic [1:0] oscillator_select;
  int n_errors = 0;
  int cmp_count = 0;
  int t0_cnt = 0;
  wsc_top #(.HOLD_CYCLES(HOLD)) wsc_top_i (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_osc_pin(wdt_osc_pin),
    .master_clear_n_pin(master_clear_n_pin), .config_word(config_word),
    .single_protect_variant(single_protect_variant), .timer0_tick(timer0_tick),
    .timer0_prescaled(timer0_prescaled), .device_reset(device_reset),
    .osc_driver_en(osc_driver_en), .io_hold(io_hold), .wdt_enabled(wdt_enabled),
    .oscillator_select(oscillator_select), .code_protect_on(code_protect_on));
  wsc_core_model wsc_core_model_i (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // watchdog oscillator: 80 ns period, offset from the system clock edges
  initial begin
    wdt_osc_pin = 0;
    #3;
    forever #40 wdt_osc_pin = ~wdt_osc_pin;
  end
  always @(posedge clk) timer0_tick <= ~timer0_tick;
  always @(posedge clk) if (timer0_prescaled === 1'b1) t0_cnt <= t0_cnt + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      n_errors++;
      $display("ERROR t=%0t bus timeout got %h exp %h", $time, done, 1'b1);
    end
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(rdata, e);
  endtask : rd
  task automatic wait_lvl(input logic v, input int lim, output int n);
    n = 0;
    while (device_reset !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_lvl
  task automatic do_reset(input logic [11:0] cw, input logic sv);
    int n;
    config_word <= cw;
    single_protect_variant <= sv;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_lvl(1'b0, 200, n);
    chk(n >= HOLD && n < HOLD + 8, 1);
  endtask : do_reset
  task automatic t_config;
    logic [11:0] cw [4] = '{12'hffc, 12'hef9, 12'h00e, 12'hff3};
    int n;
    for (int i = 0; i < 4; i++) begin
      do_reset(cw[i], i[1]);
      chk(oscillator_select, i[1:0]);
      chk(wdt_enabled, cw[i][2]);
      chk(code_protect_on, i[0]);
      rd(ADDR_CONFIG, i[1] ? cw[i] & CFG_SINGLE_MASK : cw[i]);
      rd(ADDR_STATUS, 32'h0000_0018);
    end
    bus(1'b0, 12'h010, '0);
    chk(err, 1);
    // last strap set has the watchdog off: no reset may come past one base period
    wait_lvl(1'b1, 5000, n);
    chk(device_reset, 0);
    $display("config test done");
  endtask : t_config
  task automatic t_timeout;
    int n, c;
    do_reset(12'hffc, 1'b0);
    bus(1'b1, ADDR_OPTION, '0);
    bus(1'b1, ADDR_COMMAND, 32'h0000_0001);
    c = t0_cnt;
    wait_lvl(1'b1, 6000, n);
    chk(n > 574 * 8 && n < 578 * 8, 1);
    chk(t0_cnt - c > n / 4 - 4 && t0_cnt - c < n / 4 + 4, 1);
    wait_lvl(1'b0, 200, n);
    rd(ADDR_STATUS, 32'h0000_0008);
    bus(1'b1, ADDR_OPTION, 32'h0000_0009);
    c = t0_cnt;
    repeat (4) begin
      bus(1'b1, ADDR_COMMAND, 32'h0000_0001);
      wait_lvl(1'b1, 3000, n);
      chk(device_reset, 0);
    end
    chk(t0_cnt - c, 0);
    bus(1'b1, ADDR_COMMAND, 32'h0000_0001);
    wait_lvl(1'b1, 12000, n);
    chk(n > 1150 * 8 && n < 1156 * 8, 1);
    wait_lvl(1'b0, 200, n);
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_sleep;
    int n, c;
    bus(1'b1, ADDR_COMMAND, 32'h0000_0002);
    chk({osc_driver_en, io_hold}, 2'b01);
    rd(ADDR_STATUS, 32'h0000_0011);
    repeat (200) @(posedge clk);
    chk({device_reset, io_hold}, 2'b01);
    master_clear_n_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk({device_reset, io_hold}, 2'b10);
    master_clear_n_pin <= 1'b1;
    wait_lvl(1'b0, 200, n);
    rd(ADDR_STATUS, 32'h0000_0010);
    bus(1'b1, ADDR_OPTION, 32'h0000_0002);
    c = t0_cnt;
    // Timer0 at 1:8 with a tick every second clock: 20 pulses in 320 clocks
    repeat (320) @(posedge clk);
    chk(t0_cnt - c > 18 && t0_cnt - c < 22, 1);
    bus(1'b1, ADDR_COMMAND, 32'h0000_0002);
    wait_lvl(1'b1, 6000, n);
    chk(n > 574 * 8 && n < 578 * 8, 1);
    wait_lvl(1'b0, 200, n);
    rd(ADDR_STATUS, 32'h0000_0000);
    $display("sleep test done");
  endtask : t_sleep
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    {rst, go, wr, single_protect_variant} = 4'h8;
    addr = '0;
    wdata = '0;
    master_clear_n_pin = 1'b1;
    config_word = 12'hffc;
    t_config;
    t_timeout;
    t_sleep;
    end_of_test;
  end
endmodule : tb

// ### verification/wsc_assertions.sv
// port checker for the watchdog, sleep and configuration block
`timescale 1ns/100ps
module wsc_checker
  import wsc_pkg::*;
#(
  parameter int HOLD_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and device control
  input wire logic master_clear_n_pin,
  input wire logic device_reset,
  input wire logic osc_driver_en,
  input wire logic io_hold,
  input wire logic wdt_enabled,
  input wire logic [1:0] oscillator_select
);
  logic [31:0] hold_cnt;
  logic sleep_acc;
  logic mapped;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign sleep_acc = psel && penable && pready && pwrite && paddr == ADDR_COMMAND
    && pwdata[CMD_SLEEP_BIT] && !pwdata[CMD_CLEAR_BIT];
  assign mapped = paddr inside {ADDR_OPTION, ADDR_COMMAND, ADDR_STATUS, ADDR_CONFIG};
  // length of the running reset hold, restarted by every new hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (device_reset) begin
      hold_cnt <= hold_cnt + 1;
    end else begin
      hold_cnt <= '0;
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong");
  sleep_pins_a: assert property (!osc_driver_en |-> io_hold)
    else $error("driver off without pin hold");
  sleep_cause_a: assert property ($fell(osc_driver_en) |->
    $past(sleep_acc) || $past(sleep_acc, 2))
    else $error("sleep entered without command");
  wake_reset_a: assert property ($fell(io_hold) |-> ##[0:1] device_reset)
    else $error("sleep left without reset");
  pin_wake_a: assert property (!master_clear_n_pin [*5] |-> device_reset)
    else $error("master clear ignored");
  hold_length_a: assert property ($fell(device_reset) |-> hold_cnt >= HOLD_CYCLES)
    else $error("reset hold too short");
  wdt_off_a: assert property ((!wdt_enabled && master_clear_n_pin) [*5] ##0 !device_reset
    |=> !device_reset)
    else $error("reset while watchdog disabled");
  straps_kept_a: assert property (!device_reset |->
    $stable(oscillator_select) && $stable(wdt_enabled))
    else $error("strap outputs changed");
  cover property ($fell(osc_driver_en));
  cover property ($fell(io_hold) && master_clear_n_pin);
  cover property (pready && pslverr);
endmodule : wsc_checker

bind wsc_top wsc_checker #(.HOLD_CYCLES(HOLD_CYCLES)) wsc_checker_i (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .master_clear_n_pin(master_clear_n_pin),
  .device_reset(device_reset), .osc_driver_en(osc_driver_en), .io_hold(io_hold),
  .wdt_enabled(wdt_enabled), .oscillator_select(oscillator_select));

// ### verification/wsc_core_model.sv
// processor core model: register accesses, clear and sleep commands over APB
`timescale 1ns/100ps
module wsc_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request from the bench
  input wire logic go,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic err,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {psel, penable, pwrite, done, err} <= '0;
      paddr <= '0;
      pwdata <= '0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        // released bus must not look like the old request
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (go) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end
    end
  end
endmodule : wsc_core_model
